// [common/mpasi_pkg.sv]
// Constants and types shared by the audio serial port block
// Assumes a 25 MHz system clock and a 32-bit APB register bus
package mpasi_pkg;

    // Port and pin-group counts; group 3 is the alternate set for port 0
    localparam int NPORT = 3;
    localparam int NGRP  = 4;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CFG0 = 8'h04;
    localparam logic [7:0] ADDR_CLK0 = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h1c;

    // Data widths and buffering
    localparam int WORD_W     = 32;
    localparam int PAIR_W     = 64;
    localparam int FIFO_DEPTH = 32;

    // Framing modes
    typedef enum logic [2:0] {
        MODE_LJ,
        MODE_RJ,
        MODE_I2S,
        MODE_DSP,
        MODE_TDM
    } mpasi_mode_type;

    // Control register
    typedef struct packed {
        logic       keep;
        logic       rec_en;
        logic       play_en;
        logic       alt;
        logic [1:0] sel;
    } mpasi_ctrl_type;

    // Per-port framing register
    typedef struct packed {
        logic [7:0] offset;
        logic [4:0] rsv;
        logic       six;
        logic       tri_en;
        logic       binv;
        logic       wpulse;
        logic       bmst;
        logic       wmst;
        logic [1:0] wlen;
        logic [2:0] mode;
    } mpasi_cfg_type;

    // Per-port clock register
    typedef struct packed {
        logic [7:0] rec_len;
        logic [7:0] play_len;
        logic [7:0] div;
    } mpasi_clk_type;

    // Values after reset
    localparam mpasi_ctrl_type CTRL_RST = 6'h00;
    localparam mpasi_cfg_type  CFG_RST  = 24'h000000;
    localparam mpasi_clk_type  CLK_RST  = 24'h404003;

    // Word length codes to bit counts
    localparam logic [7:0] WL16 = 8'h10;
    localparam logic [7:0] WL20 = 8'h14;
    localparam logic [7:0] WL24 = 8'h18;
    localparam logic [7:0] WL32 = 8'h20;

endpackage

// [common/mpasi_stream_if.sv]
// Valid/ready word stream between the port logic and its buffer
// Assumes source and sink share one clock
`timescale 1ns/1ns
interface mpasi_stream_if #(parameter int W = 64) ();
    logic [W-1:0] data;
    logic         valid;
    logic         ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

// [rtl/mpasi_fifo.sv]
// Record sample buffer with registered read data
// Assumes one clock; writer and reader obey valid/ready
`timescale 1ns/1ns
module mpasi_fifo
    import mpasi_pkg::*;
#(
    parameter int W     = PAIR_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rstn,
    // Write and read sides
    mpasi_stream_if.snk wr,
    mpasi_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
        logic          ov;
    } mpasi_fst_type;

    mpasi_fst_type q;
    mpasi_fst_type next_q;
    logic [W-1:0]  mem [DEPTH];
    logic [W-1:0]  rdata;
    logic          push;
    logic          pull;

    assign wr.ready = q.cnt != (AW+1)'(DEPTH);
    assign rd.valid = q.ov;
    assign rd.data  = rdata;
    assign push     = wr.valid & wr.ready;
    assign pull     = (q.cnt != '0) & (~q.ov | rd.ready);

    always_comb begin
        next_q = q;
        if (push) begin
            next_q.wp = q.wp + 1'b1;
        end
        if (pull) begin
            next_q.rp = q.rp + 1'b1;
            next_q.ov = 1'b1;
        end else if (rd.ready) begin
            next_q.ov = 1'b0;
        end
        next_q.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pull);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // Storage and output register
    always_ff @(posedge clk) begin
        if (push) begin
            mem[q.wp] <= wr.data;
        end
        if (pull) begin
            rdata <= mem[q.rp];
        end
    end

endmodule

// [rtl/mpasi_top.sv]
// Three audio serial ports with one routed to the converters, APB registers
// Assumes pins are asynchronous to clk and bit clocks are far below clk / 4
//
// Overview of operation
// - Three ports exist; only the selected one connects to the converters.
// - A fourth pin group can be switched onto port zero.
// - Left-justified, right-justified, I2S, DSP and TDM framing; PCM uses TDM.
// - MSB first; word width 16, 20, 24 or 32 bits.
// - Frame clock and bit clock each master or slave independently.
// - Frame clock marks frame start, pulse or fifty-percent square.
// - Frame rate follows the faster of record and playback rates.
// - Six-wire: record and playback each have own frame and bit clock.
// - Master bit clock comes from a programmable divider.
// - First data bit delayed by programmable bit clock periods.
// - Bit clock polarity for data transfer may be inverted.
// - Optionally tri-state serial output outside valid sample bits.
// - Master port with both paths and keep off releases all its pins.
// - Generated bit clocks toggle only while a path is powered or keep is set.
// - Option keeps generated clocks running with paths powered down.
// - Six-wire bus adds record frame clock and record bit clock lines.
`timescale 1ns/1ns
module mpasi_top
    import mpasi_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Serial pins, one bit per group
    input  wire logic [NGRP-1:0]   wclk_i,
    output logic [NGRP-1:0]        wclk_o,
    output logic [NGRP-1:0]        wclk_oe_n,
    input  wire logic [NGRP-1:0]   bclk_i,
    output logic [NGRP-1:0]        bclk_o,
    output logic [NGRP-1:0]        bclk_oe_n,
    input  wire logic [NGRP-1:0]   din,
    output logic [NGRP-1:0]        dout,
    output logic [NGRP-1:0]        dout_oe_n,
    // Record clock pins for six-wire use
    input  wire logic [NGRP-1:0]   rwclk_i,
    output logic [NGRP-1:0]        rwclk_o,
    output logic [NGRP-1:0]        rwclk_oe_n,
    input  wire logic [NGRP-1:0]   rbclk_i,
    output logic [NGRP-1:0]        rbclk_o,
    output logic [NGRP-1:0]        rbclk_oe_n,
    // Record samples from converters, left in upper half
    input  wire logic [PAIR_W-1:0] rec_data,
    input  wire logic              rec_valid,
    output logic                   rec_ready,
    // Playback samples to converters, left in upper half
    output logic [PAIR_W-1:0]      play_data,
    output logic                   play_valid
);

    typedef struct packed {
        mpasi_ctrl_type                  ctrl;
        mpasi_cfg_type [NPORT-1:0]       cfg;
        mpasi_clk_type [NPORT-1:0]       ck;
        logic                            urun;
        logic [31:0]                     prdata;
        logic [5*NGRP-1:0]               s1;
        logic [5*NGRP-1:0]               s2;
        logic [4:0]                      cur;
        logic [4:0]                      cprv;
        logic [1:0]                      bq;
        logic [1:0][7:0]                 cnt;
        logic [1:0][7:0]                 pos;
        logic [1:0]                      pw;
        logic [1:0]                      wq;
        logic [1:0][WORD_W-1:0]          rx;
        logic [1:0][WORD_W-1:0]          tx;
        logic                            dq;
        logic                            dv;
        logic [PAIR_W-1:0]               pdata;
        logic                            pvalid;
    } mpasi_st_type;

    mpasi_st_type   q;
    mpasi_st_type   next_q;
    mpasi_cfg_type  cf;
    mpasi_clk_type  ck;
    mpasi_mode_type mode;
    logic [1:0]     pi;
    logic [1:0]     g;
    logic           run;
    logic           hit;
    logic           pop;

    mpasi_stream_if #(.W(PAIR_W)) f_in ();
    mpasi_stream_if #(.W(PAIR_W)) f_out ();

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [7:0] wbits(input logic [1:0] code);
        logic [7:0] r;
        unique case (code)
            2'd0: r = WL16;
            2'd1: r = WL20;
            2'd2: r = WL24;
            2'd3: r = WL32;
        endcase
        return r;
    endfunction

    // Returns {hit, channel, bit index} for a frame position
    function automatic logic [6:0] slot(input logic [7:0] p, input logic [7:0] s0,
                                        input logic [7:0] s1, input logic [7:0] w);
        logic [7:0] d0;
        logic [7:0] d1;
        logic [6:0] r;
        d0 = p - s0;
        d1 = p - s1;
        r  = 7'h00;
        if (p >= s0 && d0 < w) begin
            r = {2'b10, d0[4:0]};
        end else if (p >= s1 && d1 < w) begin
            r = {2'b11, d1[4:0]};
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Selection and buffer

    assign pi   = (q.ctrl.sel > 2'd2) ? 2'd2 : q.ctrl.sel;
    assign g    = (pi == 2'd0 && q.ctrl.alt) ? 2'd3 : pi;
    assign cf   = q.cfg[pi];
    assign ck   = q.ck[pi];
    assign mode = mpasi_mode_type'(cf.mode);
    assign run  = q.ctrl.play_en | q.ctrl.rec_en | q.ctrl.keep;
    assign hit  = paddr[1:0] == 2'b00 && paddr[7:5] == 3'b000;

    assign f_in.data   = rec_data;
    assign f_in.valid  = rec_valid;
    assign rec_ready   = f_in.ready;
    assign f_out.ready = pop;

    mpasi_fifo #(.W(PAIR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk  (clk),
        .rstn (rstn),
        .wr   (f_in.snk),
        .rd   (f_out.src)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [2:0]  idx;
        logic [7:0]  w;
        logic [7:0]  len;
        logic [7:0]  len4;
        logic [7:0]  half;
        logic [7:0]  st;
        logic [7:0]  s0;
        logic [7:0]  s1;
        logic [7:0]  npos;
        logic [6:0]  sl;
        logic        sp;
        logic        bin;
        logic        bpv;
        logic        win;
        logic        rise;
        logic        fall;
        logic        launch;
        logic        capture;
        logic        clr;
        logic        uset;
        logic        sqr;
        next_q        = q;
        next_q.pvalid = 1'b0;
        pop           = 1'b0;
        uset          = 1'b0;
        clr           = 1'b0;
        idx           = paddr[4:2];
        sl            = 7'h00;
        npos          = 8'h00;
        sqr           = 1'b0;

        // Register writes in the access phase, read capture in the setup phase
        if (psel && penable && pwrite && hit) begin
            unique case (idx)
                3'd0: next_q.ctrl = pwdata[5:0];
                3'd1, 3'd2, 3'd3: next_q.cfg[idx[1:0] - 2'd1] = pwdata[23:0];
                3'd4, 3'd5, 3'd6: next_q.ck[idx[1:0]] = pwdata[23:0];
                3'd7: clr = pwdata[2];
            endcase
        end
        if (psel && !penable && !pwrite) begin
            unique case (idx)
                3'd0: next_q.prdata = {26'h0, q.ctrl};
                3'd1, 3'd2, 3'd3: next_q.prdata = {8'h0, q.cfg[idx[1:0] - 2'd1]};
                3'd4, 3'd5, 3'd6: next_q.prdata = {8'h0, q.ck[idx[1:0]]};
                3'd7: next_q.prdata = {21'h0, q.pos[0], q.urun, ~f_in.ready,
                                       ~f_out.valid};
            endcase
        end

        // Pin synchronisers, then the selected group
        next_q.s1   = {rbclk_i, rwclk_i, din, bclk_i, wclk_i};
        next_q.s2   = q.s1;
        next_q.cprv = q.cur;
        next_q.cur  = {q.s2[5'd16 + {3'h0, g}], q.s2[5'd12 + {3'h0, g}],
                       q.s2[5'd8 + {3'h0, g}], q.s2[5'd4 + {3'h0, g}],
                       q.s2[{3'h0, g}]};

        // Frame length
        w = wbits(cf.wlen);
        if (q.ctrl.play_en && q.ctrl.rec_en) begin
            len4 = (ck.rec_len < ck.play_len) ? ck.rec_len : ck.play_len;
        end else if (q.ctrl.rec_en) begin
            len4 = ck.rec_len;
        end else begin
            len4 = ck.play_len;
        end

        for (int p = 0; p < 2; p++) begin
            sp   = cf.six && p == 1;
            bin  = sp ? q.cur[4] : q.cur[1];
            bpv  = sp ? q.cprv[4] : q.cprv[1];
            win  = sp ? q.cur[3] : q.cur[0];
            len  = cf.six ? ((p == 1) ? ck.rec_len : ck.play_len) : len4;
            half = {1'b0, len[7:1]};

            // Bit clock edges
            rise = 1'b0;
            fall = 1'b0;
            if (cf.bmst) begin
                if (run) begin
                    if (q.cnt[p] >= ck.div) begin
                        next_q.cnt[p] = 8'h00;
                        next_q.bq[p]  = ~q.bq[p];
                        rise          = ~q.bq[p];
                        fall          = q.bq[p];
                    end else begin
                        next_q.cnt[p] = q.cnt[p] + 8'h01;
                    end
                end else begin
                    next_q.cnt[p] = 8'h00;
                    next_q.bq[p]  = 1'b0;
                end
            end else begin
                rise = bin & ~bpv;
                fall = ~bin & bpv;
            end
            launch  = cf.binv ? rise : fall;
            capture = cf.binv ? fall : rise;

            // Slot positions per framing
            st = cf.offset + {7'h0, mode == MODE_I2S};
            s0 = (mode == MODE_RJ) ? half - w + cf.offset : st;
            if (mode == MODE_DSP || mode == MODE_TDM) begin
                s1 = st + w;
            end else if (mode == MODE_RJ) begin
                s1 = len - w + cf.offset;
            end else begin
                s1 = half + st;
            end

            if (launch) begin
                if (cf.wmst) begin
                    npos = (q.pos[p] >= len - 8'h01) ? 8'h00 : q.pos[p] + 8'h01;
                end else if (win != q.pw[p] && win == (mode != MODE_I2S)) begin
                    npos = 8'h00;
                end else begin
                    npos = q.pos[p] + 8'h01;
                end
                next_q.pos[p] = npos;
                next_q.pw[p]  = win;
                sqr           = (npos < half) ^ (mode == MODE_I2S);
                next_q.wq[p]  = cf.wpulse ? (npos == 8'h00) : sqr;
                if (p == 1) begin
                    if (npos == 8'h00 && q.ctrl.rec_en) begin
                        if (f_out.valid) begin
                            pop       = 1'b1;
                            next_q.tx = f_out.data;
                        end else begin
                            uset      = 1'b1;
                            next_q.tx = '0;
                        end
                    end
                    sl        = slot(npos, s0, s1, w);
                    next_q.dv = sl[6];
                    next_q.dq = sl[6] & next_q.tx[~sl[5]][5'd31 - sl[4:0]];
                end
            end

            if (capture && p == 0) begin
                sl = slot(q.pos[0], s0, s1, w);
                if (sl[6]) begin
                    next_q.rx[~sl[5]][5'd31 - sl[4:0]] = q.cur[2];
                    if (sl[5] && {3'h0, sl[4:0]} == w - 8'h01 && q.ctrl.play_en) begin
                        next_q.pdata  = {next_q.rx[1], next_q.rx[0]};
                        next_q.pvalid = 1'b1;
                    end
                end
            end
        end

        // Four-wire: record path shares playback clocks
        if (!cf.six) begin
            next_q.bq[1]  = next_q.bq[0];
            next_q.cnt[1] = next_q.cnt[0];
            next_q.pos[1] = next_q.pos[0];
            next_q.pw[1]  = next_q.pw[0];
            next_q.wq[1]  = next_q.wq[0];
        end

        // Underrun flag, set wins over clear
        next_q.urun = (q.urun & ~clr) | uset;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q      <= '0;
            q.ctrl <= CTRL_RST;
            q.cfg  <= {NPORT{CFG_RST}};
            q.ck   <= {NPORT{CLK_RST}};
        end else begin
            q <= next_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata     = q.prdata;
    assign pready     = 1'b1;
    assign pslverr    = psel & penable & ~hit;
    assign play_data  = q.pdata;
    assign play_valid = q.pvalid;
    assign wclk_o     = {NGRP{q.wq[0]}};
    assign bclk_o     = {NGRP{q.bq[0]}};
    assign rwclk_o    = {NGRP{q.wq[1]}};
    assign rbclk_o    = {NGRP{q.bq[1]}};
    assign dout       = {NGRP{q.dq}};

    for (genvar i = 0; i < NGRP; i++) begin : g_pin
        logic on;
        assign on            = (g == 2'(i)) & run;
        assign wclk_oe_n[i]  = ~(on & cf.wmst);
        assign bclk_oe_n[i]  = ~(on & cf.bmst);
        assign rwclk_oe_n[i] = ~(on & cf.six & cf.wmst);
        assign rbclk_oe_n[i] = ~(on & cf.six & cf.bmst);
        assign dout_oe_n[i]  = ~((g == 2'(i)) & q.ctrl.rec_en & (~cf.tri_en | q.dv));
    end

endmodule

// [tb/mpasi_props.sv]
// Port checker for the audio serial port block
// Assumes binding into mpasi_top; sees its ports only
`timescale 1ns/1ns
module mpasi_props
    import mpasi_pkg::*;
(
    // Clock and reset
    input wire logic            clk,
    input wire logic            rstn,
    // Register bus
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [7:0]      paddr,
    input wire logic [31:0]     pwdata,
    input wire logic            pready,
    input wire logic            pslverr,
    // Pins
    input wire logic [NGRP-1:0] wclk_oe_n,
    input wire logic [NGRP-1:0] bclk_oe_n,
    input wire logic [NGRP-1:0] dout_oe_n,
    input wire logic [NGRP-1:0] bclk_o,
    // Streams
    input wire logic            rec_ready,
    input wire logic            play_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Any path or keep bit set
    logic on;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            on <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL) begin
            on <= |pwdata[5:3];
        end
    end

    ////////////////////////////////////////////////////////////
    property p_one_dout; $onehot0(~dout_oe_n); endproperty
    a_one_dout: assert property (p_one_dout) else $error("two data groups driven");
    property p_one_bclk; $onehot0(~bclk_oe_n); endproperty
    a_one_bclk: assert property (p_one_bclk) else $error("two bit clocks driven");
    property p_one_wclk; $onehot0(~wclk_oe_n); endproperty
    a_one_wclk: assert property (p_one_wclk) else $error("two frame clocks driven");
    property p_same_grp; (!(&wclk_oe_n) && !(&bclk_oe_n)) |-> wclk_oe_n == bclk_oe_n; endproperty
    a_same_grp: assert property (p_same_grp) else $error("clocks on two groups");
    property p_off; !on |-> &{wclk_oe_n, bclk_oe_n, dout_oe_n}; endproperty
    a_off: assert property (p_off) else $error("pins driven while off");
    property p_runs; $fell(&bclk_oe_n) |-> ##[1:600] $changed(bclk_o[0]); endproperty
    a_runs: assert property (p_runs) else $error("driven bit clock idle");
    property p_pulse; play_valid |=> !play_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("playback strobe too long");
    property p_rdy; psel |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("bus wait inserted");
    property p_err; psel && penable |-> pslverr == (paddr > 8'h1c || paddr[1:0] != 2'b00);
    endproperty
    a_err: assert property (p_err) else $error("wrong error response");

    c_alt: cover property (!bclk_oe_n[3]);
    c_play: cover property (play_valid);
    c_full: cover property ($fell(rec_ready));
endmodule

bind mpasi_top mpasi_props u_props (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .wclk_oe_n(wclk_oe_n), .bclk_oe_n(bclk_oe_n), .dout_oe_n(dout_oe_n),
    .bclk_o(bclk_o), .rec_ready(rec_ready), .play_valid(play_valid)
);

// [tb/mpasi_far_end.sv]
// Far-end processor: drives frame and bit clock, sends and captures words
// Assumes left-justified 32-bit words in a 64-bit frame, clock slave block
`timescale 1ns/1ns
module mpasi_far_end #(
    parameter int HALF = 8
) (
    // Clock and control
    input  wire logic        clk,
    input  wire logic        run,
    input  wire logic [63:0] tx,
    // Serial lines
    output logic             wclk,
    output logic             bclk,
    output logic             sdi,
    input  wire logic        sdo,
    // Last whole frame
    output logic [63:0]      got,
    output logic             done
);
    int          ph   = 0;
    int          pos  = 63;
    logic        live = 1'b0;
    logic [63:0] sh   = '0;

    initial begin
        {wclk, bclk, sdi, done} = 4'h0;
        got = '0;
    end

    always @(posedge clk) begin
        done <= 1'b0;
        if (!run) begin
            // Clocks still, data line not stale
            ph   <= 0;
            pos  <= 63;
            live <= 1'b0;
            bclk <= 1'b0;
            wclk <= 1'b0;
            sdi  <= ~sdi;
        end else if (ph == HALF - 1) begin
            // Sample edge
            ph   <= ph + 1;
            bclk <= 1'b1;
            sh   <= {sh[62:0], sdo};
            if (pos == 63 && live) begin
                got  <= {sh[62:0], sdo};
                done <= 1'b1;
            end
        end else if (ph == 2 * HALF - 1) begin
            // Launch edge, frame starts at position 0
            ph   <= 0;
            pos  <= (pos + 1) % 64;
            live <= 1'b1;
            bclk <= 1'b0;
            wclk <= ((pos + 1) % 64) < 32;
            sdi  <= tx[63 - (pos + 1) % 64];
        end else begin
            ph <= ph + 1;
        end
    end
endmodule

// [tb/test_multi_port_audio_serial_interface.sv]
// Self-checking bench for the audio serial port block
// Assumes far-end model on group 0 and the bound checker
`timescale 1ns/1ns
module test_multi_port_audio_serial_interface
    import mpasi_pkg::*;
;
    localparam logic [63:0] FAR_TX = 64'ha5c3_1e0f_5a3c_e1f0;

    logic              clk = 1'b0, rstn = 1'b0, run = 1'b0;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0;
    logic [31:0]       prdata, rd;
    logic              pready, pslverr, err;
    logic [NGRP-1:0]   bclk_o, wclk_oe_n, bclk_oe_n, dout, dout_oe_n;
    logic [PAIR_W-1:0] rec_data = '0, play_data, play_last = '0, f_got;
    logic              rec_valid = 1'b0, rec_ready, play_valid;
    logic              f_wclk, f_bclk, f_sdi, f_done;
    int                fail_count = 0;
    int                n_checks = 0;
    wire               f_sdo = dout_oe_n[0] ? 1'bz : dout[0];

    always #20 clk = ~clk;

    always @(posedge clk) if (play_valid === 1'b1) play_last <= play_data;

    mpasi_top uut (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wclk_i({3'b000, f_wclk}), .wclk_o(),
        .wclk_oe_n(wclk_oe_n), .bclk_i({3'b000, f_bclk}), .bclk_o(bclk_o),
        .bclk_oe_n(bclk_oe_n), .din({3'b000, f_sdi}), .dout(dout),
        .dout_oe_n(dout_oe_n), .rwclk_i(4'h0), .rwclk_o(), .rwclk_oe_n(),
        .rbclk_i(4'h0), .rbclk_o(), .rbclk_oe_n(), .rec_data(rec_data),
        .rec_valid(rec_valid), .rec_ready(rec_ready), .play_data(play_data),
        .play_valid(play_valid)
    );

    mpasi_far_end #(.HALF(8)) far (
        .clk(clk), .run(run), .tx(FAR_TX), .wclk(f_wclk), .bclk(f_bclk),
        .sdi(f_sdi), .sdo(f_sdo), .got(f_got), .done(f_done)
    );

    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic push(input logic [63:0] v);
        @(posedge clk);
        rec_data <= v;
        rec_valid <= 1'b1;
        @(posedge clk);
        while (rec_ready !== 1'b1) @(posedge clk);
        rec_valid <= 1'b0;
    endtask

    task automatic frame();
        @(posedge clk iff f_done === 1'b1);
    endtask

    function automatic logic [63:0] pair(input int i);
        return {32'h1000_0000 + 32'(i), 32'hf000_0000 - 32'(i)};
    endfunction

    task automatic t_reset();
        chk(64'({wclk_oe_n, bclk_oe_n, dout_oe_n}), 64'hfff);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(64'(rd), 64'h0);
        apb(1'b0, ADDR_CLK0, 32'h0);
        chk(64'(rd), 64'h404003);
        apb(1'b1, ADDR_CFG0, 32'hffff_ffff);
        apb(1'b0, ADDR_CFG0, 32'h0);
        chk(64'(rd), 64'hff_ffff);
        apb(1'b1, ADDR_CFG0, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk(64'(err), 64'h1);
        apb(1'b1, 8'h02, 32'h0);
        chk(64'(err), 64'h1);
    endtask

    task automatic t_master(input int p, input logic [31:0] ctl, input logic [7:0] dv,
                            input logic [3:0] exp);
        int n;
        apb(1'b1, ADDR_CFG0 + 8'(4 * p), 32'h60);
        apb(1'b1, ADDR_CLK0 + 8'(4 * p), {16'h0040, 8'h40, dv});
        apb(1'b1, ADDR_CTRL, ctl);
        @(negedge clk);
        chk(64'(bclk_oe_n), 64'(exp));
        chk(64'(wclk_oe_n), 64'(exp));
        n = 0;
        @(negedge clk iff bclk_o[0] === 1'b0);
        @(negedge clk iff bclk_o[0] === 1'b1);
        while (bclk_o[0] === 1'b1) begin
            @(negedge clk);
            n++;
        end
        chk(64'(n), 64'(dv) + 64'd1);
        apb(1'b1, ADDR_CTRL, 32'h0);
        @(negedge clk);
        chk(64'({wclk_oe_n, bclk_oe_n, dout_oe_n}), 64'hfff);
        apb(1'b1, ADDR_CFG0 + 8'(4 * p), 32'h0);
    endtask

    task automatic t_fifo();
        int k;
        apb(1'b1, ADDR_STAT, 32'h4);
        apb(1'b1, ADDR_CFG0, 32'h18);
        k = 0;
        while (rec_ready === 1'b1 && k < 40) begin
            push(pair(k));
            k++;
            @(negedge clk);
        end
        chk(64'(k), 64'(FIFO_DEPTH + 1));
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(64'(rd[1:0]), 64'h2);
        run <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h18);
        for (int i = 0; i < 3 && f_got !== pair(0); i++) frame();
        chk(f_got, pair(0));
        for (int i = 1; i < 4; i++) begin
            frame();
            chk(f_got, pair(i));
        end
        chk(play_last, FAR_TX);
        for (int i = 0; i < 40 && rd[0] !== 1'b1; i++) begin
            frame();
            apb(1'b0, ADDR_STAT, 32'h0);
        end
        repeat (3) frame();
        chk(f_got, 64'h0);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(64'(rd[2]), 64'h1);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_STAT, 32'h4);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(64'(rd[2]), 64'h0);
        run <= 1'b0;
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        fail_count++;
        end_sim();
    end

    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_master(0, 32'h20, 8'h03, 4'b1110);
        t_master(0, 32'h24, 8'h07, 4'b0111);
        t_master(1, 32'h09, 8'h00, 4'b1101);
        t_master(2, 32'h12, 8'h01, 4'b1011);
        t_fifo();
        end_sim();
    end
endmodule
